// ===== bench/csb_codec_model.sv
`timescale 1ns/1ps
`default_nettype none

// behavioural codec side: valid flags, framer pulses and the irq pin
module csb_codec_model (
   input wire logic clk,
   output var csb_pkg::csb_frame_ev_t frame_ev,
   output var logic codec_interrupt_input
);
   import csb_pkg::*;

   // bit 7 snd sf0, 6 snd sf1, 5 tel sf0, 4 tel sf1, 3..0 pulses
   logic [7:0] ev_q = 8'h00;

   assign frame_ev = csb_frame_ev_t'(ev_q);

   initial begin
      codec_interrupt_input = 1'b0;
   end

   // a flag is a level and stays put until the next call
   task automatic set_line(input int i, input logic v);
      @(posedge clk);
      ev_q[i] <= v;
   endtask

   // word and start pulses are one cycle wide, never longer
   task automatic pulse(input int i);
      @(posedge clk);
      ev_q[i] <= 1'b1;
      @(posedge clk);
      ev_q[i] <= 1'b0;
   endtask

   // the pin is held as a level, the block must resynchronise it
   task automatic set_pin(input logic v);
      @(posedge clk);
      codec_interrupt_input <= v;
   endtask
endmodule

`default_nettype wire

// ===== bench/csb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"

module csb_top_tb;
   import csb_pkg::*;

   logic clk;
   logic rst;
   csb_bus_req_t bus_req;
   logic [31:0] rd_data;
   csb_frame_ev_t frame_ev;
   logic codec_interrupt_input;
   csb_dma_cfg_t dma_cfg;
   logic [30:0] control_out;
   logic irq;
   int err_count = 0;
   int checked = 0;

   csb_top i_dut (.clk(clk), .rst(rst), .bus_req(bus_req),
      .rd_data(rd_data), .frame_ev(frame_ev),
      .codec_interrupt_input(codec_interrupt_input),
      .dma_cfg(dma_cfg), .control_out(control_out), .irq(irq));

   csb_codec_model i_codec (.clk(clk), .frame_ev(frame_ev),
      .codec_interrupt_input(codec_interrupt_input));

   // 200 MHz module clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one-cycle write strobe, effective at the edge that samples it
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_check(input string what, input logic [11:0] a,
         input logic [31:0] exp);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      check(what, rd_data, exp);
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
   endtask

   task automatic t_reset();
      check("irq", {31'h0, irq}, 32'h0);
      check("ctrl_out", {1'b0, control_out}, 32'h0);
      check("cfg", {31'h0, dma_cfg === '0}, 32'h1);
      rd_check("ctrl", `CSB_OFF_CONTROL, 32'h0);
      wait_cyc(1);
      check("rd_idle", rd_data, 32'h0);
      rd_check("mask", `CSB_OFF_IRQ_MASK, 32'h0);
      $display("test reset done");
   endtask

   // sound bases apart with a wrapping last word, telecom ones shared
   task automatic t_regs();
      logic [31:0] wd [4];
      wd = '{32'h1234_5678, 32'hffff_fffc, 32'h0000_4000, 32'h0000_4000};
      // reserved bits set on purpose, they must not leak into the sizes
      bus_wr(`CSB_OFF_BUF_SIZE, (32'habc << 18) | (32'h123 << 2)
         | 32'hc003_c003);
      for (int i = 0; i < 4; i++) begin
         bus_wr(12'h064 + 12'(4 * i), wd[i]);
      end
      // only the high address bits differ: an alias must not hit a base
      bus_wr(12'hf64, 32'hffff_ffff);
      wait_cyc(3);
      check("snd_size", {20'h0, dma_cfg.sound_buffer_size}, 32'habc);
      check("tel_size", {20'h0, dma_cfg.telecom_buffer_size}, 32'h123);
      check("snd_rx", {2'b0, dma_cfg.sound_rx_base}, wd[0] >> 2);
      check("snd_tx", {2'b0, dma_cfg.sound_tx_base}, wd[1] >> 2);
      check("tel_rx", {2'b0, dma_cfg.telecom_rx_base}, wd[2] >> 2);
      check("tel_tx", {2'b0, dma_cfg.telecom_tx_base}, wd[3] >> 2);
      check("snd_rx_l", {2'b0, dma_cfg.sound_rx_last},
         {2'b0, wd[0][31:2] + 30'habc});
      check("snd_tx_l", {2'b0, dma_cfg.sound_tx_last},
         {2'b0, wd[1][31:2] + 30'habc});
      check("tel_rx_l", {2'b0, dma_cfg.telecom_rx_last},
         {2'b0, wd[2][31:2] + 30'h123});
      check("tel_tx_l", {2'b0, dma_cfg.telecom_tx_last},
         {2'b0, wd[3][31:2] + 30'h123});
      rd_check("size_wo", `CSB_OFF_BUF_SIZE, 32'h0);
      rd_check("unmapped", 12'hf87, 32'h0);
      $display("test regs done");
   endtask

   // every event source once, each must set exactly its own bit
   task automatic t_events();
      bus_wr(`CSB_OFF_IRQ_MASK, 32'h0000_03ff);
      bus_wr(`CSB_OFF_CONTROL, 32'h0000_0001);
      // control holds a one now, so an aliased decode would show it
      rd_check("alias", 12'hf77, 32'h0);
      for (int k = 0; k < 10; k++) begin
         case (k)
            0: i_codec.set_line(7, 1'b1);
            1: i_codec.set_line(7, 1'b0);
            2: i_codec.set_line(5, 1'b1);
            3: i_codec.set_line(5, 1'b0);
            4: i_codec.pulse(3);
            5: i_codec.pulse(2);
            6: i_codec.pulse(1);
            7: i_codec.pulse(0);
            default: i_codec.set_pin(k == 8);
         endcase
         wait_cyc(6);
         check("irq_set", {31'h0, irq}, 32'h1);
         rd_check("status", `CSB_OFF_IRQ_STATUS, 32'h1 << k);
         rd_check("ctrl", `CSB_OFF_CONTROL, {k == 8, 31'h1});
         bus_wr(`CSB_OFF_IRQ_STATUS, 32'h1 << k);
         rd_check("cleared", `CSB_OFF_IRQ_STATUS, 32'h0);
         check("irq_clr", {31'h0, irq}, 32'h0);
      end
      $display("test events done");
   endtask

   // with both selects at 1 only the subframe 1 flags may count
   task automatic t_select();
      bus_wr(`CSB_OFF_CONTROL, 32'h0000_00c1);
      i_codec.set_line(7, 1'b1);
      i_codec.set_line(5, 1'b1);
      wait_cyc(4);
      rd_check("unsel", `CSB_OFF_IRQ_STATUS, 32'h0);
      i_codec.set_line(6, 1'b1);
      i_codec.set_line(4, 1'b1);
      wait_cyc(4);
      rd_check("sel", `CSB_OFF_IRQ_STATUS, 32'h5);
      bus_wr(`CSB_OFF_CONTROL, 32'h0);
      for (int i = 4; i < 8; i++) begin
         i_codec.set_line(i, 1'b0);
      end
      $display("test select done");
   endtask

   // masked event stays silent; disabling drops state, keeps control
   task automatic t_disable();
      bus_wr(`CSB_OFF_IRQ_MASK, 32'h0000_0010);
      bus_wr(`CSB_OFF_CONTROL, 32'h0000_5a01);
      i_codec.pulse(1);
      wait_cyc(3);
      check("masked", {31'h0, irq}, 32'h0);
      i_codec.pulse(3);
      wait_cyc(3);
      check("unmasked", {31'h0, irq}, 32'h1);
      rd_check("both", `CSB_OFF_IRQ_STATUS, 32'h50);
      bus_wr(`CSB_OFF_CONTROL, 32'h0000_5a00);
      i_codec.pulse(3);
      wait_cyc(3);
      rd_check("held", `CSB_OFF_IRQ_STATUS, 32'h0);
      rd_check("kept", `CSB_OFF_CONTROL, 32'h0000_5a00);
      check("ctrl_out", {1'b0, control_out}, 32'h0000_5a00);
      check("irq_off", {31'h0, irq}, 32'h0);
      $display("test disable done");
   endtask

   // main sequence, ending with a second reset and its reset check
   initial begin
      rst = 1'b1;
      bus_req = '0;
      do_reset();
      t_reset();
      t_regs();
      t_events();
      t_select();
      t_disable();
      do_reset();
      t_reset();
      complete_run();
   end

   // the whole run needs a few hundred cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run();
   end
endmodule

`default_nettype wire

// ===== rtl/csb_defines.svh
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

// register byte offsets
`define CSB_OFF_BUF_SIZE 12'h060
`define CSB_OFF_SND_RX_BASE 12'h064
`define CSB_OFF_SND_TX_BASE 12'h068
`define CSB_OFF_TEL_RX_BASE 12'h06c
`define CSB_OFF_TEL_TX_BASE 12'h070
`define CSB_OFF_CONTROL 12'h074
`define CSB_OFF_IRQ_STATUS 12'h080
`define CSB_OFF_IRQ_MASK 12'h084

// field positions in the buffer size register
`define CSB_SND_SIZE_HI 29
`define CSB_SND_SIZE_LO 18
`define CSB_TEL_SIZE_HI 13
`define CSB_TEL_SIZE_LO 2

// start address field
`define CSB_BASE_HI 31
`define CSB_BASE_LO 2

// control register bit positions
`define CSB_CTRL_CODEC_IRQ 31
`define CSB_CTRL_CNT_TEST 30
`define CSB_CTRL_XFER_TEST 29
`define CSB_CTRL_SEL_TEL 7
`define CSB_CTRL_SEL_SND 6
`define CSB_CTRL_ENABLE 0

// event bit positions in status and mask
`define CSB_EV_SND_RISE 0
`define CSB_EV_SND_FALL 1
`define CSB_EV_TEL_RISE 2
`define CSB_EV_TEL_FALL 3
`define CSB_EV_SND_WORD 4
`define CSB_EV_TEL_WORD 5
`define CSB_EV_SF0_START 6
`define CSB_EV_SF1_START 7
`define CSB_EV_IRQ_RISE 8
`define CSB_EV_IRQ_FALL 9

// reset values
`define CSB_CTRL_RESET 31'h0000_0000
`define CSB_SIZE_RESET 12'h000
`define CSB_BASE_RESET 30'h0000_0000
`define CSB_EV_RESET 10'h000

`endif

// ===== rtl/csb_pkg.sv
package csb_pkg;

   // one register bus request, all signals of a cycle
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } csb_bus_req_t;

   // frame level indications from the serial framer, same clock
   typedef struct packed {
      logic sound_valid_sf0;
      logic sound_valid_sf1;
      logic telecom_valid_sf0;
      logic telecom_valid_sf1;
      logic sound_word_ready;
      logic telecom_word_ready;
      logic subframe0_start;
      logic subframe1_start;
   } csb_frame_ev_t;

   // buffer geometry handed to the transfer engines
   typedef struct packed {
      logic [11:0] sound_buffer_size;
      logic [11:0] telecom_buffer_size;
      logic [29:0] sound_rx_base;
      logic [29:0] sound_tx_base;
      logic [29:0] telecom_rx_base;
      logic [29:0] telecom_tx_base;
      logic [29:0] sound_rx_last;
      logic [29:0] sound_tx_last;
      logic [29:0] telecom_rx_last;
      logic [29:0] telecom_tx_last;
   } csb_dma_cfg_t;

   // complete state of the top module
   typedef struct packed {
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic snd_valid;
      logic tel_valid;
      logic [30:0] ctrl;
      logic [9:0] status;
      logic [9:0] mask;
      logic irq;
      logic [31:0] rdata;
      csb_dma_cfg_t cfg;
   } csb_state_t;

endpackage

// ===== rtl/csb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"

// Summary of operation
// RL1 - interrupt on each sound valid flag edge
// RL2 - interrupt on each telecom valid flag edge
// RL3 - interrupt when sound word is ready
// RL4 - interrupt when telecom word is ready
// RL5 - interrupt at start of subframe 0
// RL6 - interrupt at start of subframe 1
// RL7 - interrupt on each codec interrupt pin edge
// RL8 - sound size from bits 29 to 18
// RL9 - sound last word is base plus size
// RL10 - telecom size from bits 13 to 2
// RL11 - telecom last word is base plus size
// RL12 - separate sound receive and transmit bases
// RL13 - separate telecom receive and transmit bases
// RL14 - control bit 31 reads codec pin level
// RL15 - software keeps both test bits cleared
// RL16 - sound select picks subframe 1 or 0
// RL17 - telecom select picks subframe 1 or 0
// RL18 - disable holds module reset, control kept
// RL19 - edges from consecutive samples, one-cycle pulses
module csb_top (
   input wire logic clk,
   input wire logic rst,
   input wire csb_pkg::csb_bus_req_t bus_req,
   output logic [31:0] rd_data,
   input wire csb_pkg::csb_frame_ev_t frame_ev,
   input wire logic codec_interrupt_input,
   output csb_pkg::csb_dma_cfg_t dma_cfg,
   output logic [30:0] control_out,
   output logic irq
);
   import csb_pkg::*;

   csb_state_t st_q;
   csb_state_t st_d;

   logic module_enable;
   logic sound_subframe_select;
   logic telecom_subframe_select;
   logic snd_flag;
   logic tel_flag;
   logic [9:0] ev;
   logic [9:0] w1c;

   // word address of the last buffer entry
   function automatic logic [29:0] last_addr(
      input logic [29:0] base,
      input logic [11:0] size
   );
      last_addr = base + {18'h0_0000, size};
   endfunction

   // register hit for a given offset
   function automatic logic hit(
      input logic [11:0] addr,
      input logic [11:0] off
   );
      hit = (addr == off);
   endfunction

   // control fields that steer the event logic
   assign module_enable = st_q.ctrl[`CSB_CTRL_ENABLE];
   assign sound_subframe_select = st_q.ctrl[`CSB_CTRL_SEL_SND];
   assign telecom_subframe_select = st_q.ctrl[`CSB_CTRL_SEL_TEL];

   // pick the valid flag of the selected subframe
   assign snd_flag = sound_subframe_select ? frame_ev.sound_valid_sf1 :
                     frame_ev.sound_valid_sf0; // RL16
   assign tel_flag = telecom_subframe_select ?
                     frame_ev.telecom_valid_sf1 :
                     frame_ev.telecom_valid_sf0; // RL17

   // edge and data events; the disabled module sees none
   always_comb begin
      ev = `CSB_EV_RESET;
      if (module_enable) begin
         ev[`CSB_EV_SND_RISE] = snd_flag & ~st_q.snd_valid; // RL1
         ev[`CSB_EV_SND_FALL] = ~snd_flag & st_q.snd_valid; // RL1
         ev[`CSB_EV_TEL_RISE] = tel_flag & ~st_q.tel_valid; // RL2
         ev[`CSB_EV_TEL_FALL] = ~tel_flag & st_q.tel_valid; // RL2
         ev[`CSB_EV_SND_WORD] = frame_ev.sound_word_ready; // RL3
         ev[`CSB_EV_TEL_WORD] = frame_ev.telecom_word_ready; // RL4
         ev[`CSB_EV_SF0_START] = frame_ev.subframe0_start; // RL5
         ev[`CSB_EV_SF1_START] = frame_ev.subframe1_start; // RL6
         ev[`CSB_EV_IRQ_RISE] = st_q.pin_sync & ~st_q.pin_prev; // RL7
         ev[`CSB_EV_IRQ_FALL] = ~st_q.pin_sync & st_q.pin_prev; // RL7
      end
   end

   // write-one-to-clear mask for the status register
   assign w1c = (bus_req.wr && hit(bus_req.addr, `CSB_OFF_IRQ_STATUS)) ?
                bus_req.wdata[9:0] : 10'h000;

   // next state of the whole block
   always_comb begin
      st_d = st_q;
      // two-stage synchroniser, only the second stage feeds logic
      st_d.pin_meta = codec_interrupt_input;
      st_d.pin_sync = st_q.pin_meta;
      // previous samples; held at their reset value while disabled,
      // like the status register and irq, so a level already high when
      // the module is switched on counts as a rising edge
      if (module_enable) begin
         st_d.pin_prev = st_q.pin_sync; // RL19
         st_d.snd_valid = snd_flag; // RL19
         st_d.tel_valid = tel_flag; // RL19
      end else begin
         st_d.pin_prev = 1'b0; // RL18
         st_d.snd_valid = 1'b0; // RL18
         st_d.tel_valid = 1'b0; // RL18
      end
      // register writes
      if (bus_req.wr) begin
         if (hit(bus_req.addr, `CSB_OFF_BUF_SIZE)) begin
            st_d.cfg.sound_buffer_size =
               bus_req.wdata[`CSB_SND_SIZE_HI:`CSB_SND_SIZE_LO]; // RL8
            st_d.cfg.telecom_buffer_size =
               bus_req.wdata[`CSB_TEL_SIZE_HI:`CSB_TEL_SIZE_LO]; // RL10
         end
         if (hit(bus_req.addr, `CSB_OFF_SND_RX_BASE)) begin
            st_d.cfg.sound_rx_base =
               bus_req.wdata[`CSB_BASE_HI:`CSB_BASE_LO]; // RL12
         end
         if (hit(bus_req.addr, `CSB_OFF_SND_TX_BASE)) begin
            st_d.cfg.sound_tx_base =
               bus_req.wdata[`CSB_BASE_HI:`CSB_BASE_LO]; // RL12
         end
         if (hit(bus_req.addr, `CSB_OFF_TEL_RX_BASE)) begin
            st_d.cfg.telecom_rx_base =
               bus_req.wdata[`CSB_BASE_HI:`CSB_BASE_LO]; // RL13
         end
         if (hit(bus_req.addr, `CSB_OFF_TEL_TX_BASE)) begin
            st_d.cfg.telecom_tx_base =
               bus_req.wdata[`CSB_BASE_HI:`CSB_BASE_LO]; // RL13
         end
         // bit 31 is the pin level and cannot be written
         if (hit(bus_req.addr, `CSB_OFF_CONTROL)) begin
            st_d.ctrl = bus_req.wdata[30:0]; // RL14
         end
         if (hit(bus_req.addr, `CSB_OFF_IRQ_MASK)) begin
            st_d.mask = bus_req.wdata[9:0];
         end
      end
      // last entries follow the stored base and size one cycle later
      st_d.cfg.sound_rx_last = last_addr(st_q.cfg.sound_rx_base,
         st_q.cfg.sound_buffer_size); // RL9
      st_d.cfg.sound_tx_last = last_addr(st_q.cfg.sound_tx_base,
         st_q.cfg.sound_buffer_size); // RL9
      st_d.cfg.telecom_rx_last = last_addr(st_q.cfg.telecom_rx_base,
         st_q.cfg.telecom_buffer_size); // RL11
      st_d.cfg.telecom_tx_last = last_addr(st_q.cfg.telecom_tx_base,
         st_q.cfg.telecom_buffer_size); // RL11
      // sticky status: a new event wins over a clear in the same cycle
      if (module_enable) begin
         st_d.status = (st_q.status & ~w1c) | ev;
      end else begin
         st_d.status = `CSB_EV_RESET; // RL18
      end
      st_d.irq = |(st_d.status & st_d.mask);
      // read data stands only in the cycle after the read strobe
      st_d.rdata = 32'h0000_0000;
      if (bus_req.rd) begin
         if (hit(bus_req.addr, `CSB_OFF_CONTROL)) begin
            st_d.rdata = {st_q.pin_sync, st_q.ctrl}; // RL14
         end else if (hit(bus_req.addr, `CSB_OFF_IRQ_STATUS)) begin
            st_d.rdata = {22'h00_0000, st_q.status};
         end else if (hit(bus_req.addr, `CSB_OFF_IRQ_MASK)) begin
            st_d.rdata = {22'h00_0000, st_q.mask};
         end
      end
   end

   // state register; base and size have no defined power-on value,
   // zero keeps simulation clean
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q.pin_meta <= 1'b0;
         st_q.pin_sync <= 1'b0;
         st_q.pin_prev <= 1'b0;
         st_q.snd_valid <= 1'b0;
         st_q.tel_valid <= 1'b0;
         st_q.ctrl <= `CSB_CTRL_RESET; // RL15
         st_q.status <= `CSB_EV_RESET;
         st_q.mask <= `CSB_EV_RESET;
         st_q.irq <= 1'b0;
         st_q.rdata <= 32'h0000_0000;
         st_q.cfg.sound_buffer_size <= `CSB_SIZE_RESET;
         st_q.cfg.telecom_buffer_size <= `CSB_SIZE_RESET;
         st_q.cfg.sound_rx_base <= `CSB_BASE_RESET;
         st_q.cfg.sound_tx_base <= `CSB_BASE_RESET;
         st_q.cfg.telecom_rx_base <= `CSB_BASE_RESET;
         st_q.cfg.telecom_tx_base <= `CSB_BASE_RESET;
         st_q.cfg.sound_rx_last <= `CSB_BASE_RESET;
         st_q.cfg.sound_tx_last <= `CSB_BASE_RESET;
         st_q.cfg.telecom_rx_last <= `CSB_BASE_RESET;
         st_q.cfg.telecom_tx_last <= `CSB_BASE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flip-flops
   assign rd_data = st_q.rdata;
   assign dma_cfg = st_q.cfg;
   assign control_out = st_q.ctrl;
   assign irq = st_q.irq;

   // checks on the event and register logic
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_sound_rise_set: assert property ( // RL1
      module_enable && snd_flag && !st_q.snd_valid
      |=> st_q.status[`CSB_EV_SND_RISE])
      else $error("sound valid rise not latched");

   a_sound_fall_set: assert property ( // RL16
      module_enable && sound_subframe_select &&
      !frame_ev.sound_valid_sf1 && st_q.snd_valid
      |=> st_q.status[`CSB_EV_SND_FALL])
      else $error("sound valid fall from subframe 1 not latched");

   a_tel_edge_set: assert property ( // RL2
      module_enable && (tel_flag != st_q.tel_valid)
      |=> st_q.status[`CSB_EV_TEL_RISE] || st_q.status[`CSB_EV_TEL_FALL])
      else $error("telecom valid edge not latched");

   a_tel_select_sf0: assert property ( // RL17
      module_enable && !telecom_subframe_select &&
      frame_ev.telecom_valid_sf0 |=> st_q.tel_valid)
      else $error("telecom flag not taken from subframe 0");

   a_sound_word_set: assert property ( // RL3
      module_enable && frame_ev.sound_word_ready
      |=> st_q.status[`CSB_EV_SND_WORD])
      else $error("sound word event lost");

   a_tel_word_set: assert property ( // RL4
      module_enable && frame_ev.telecom_word_ready
      |=> st_q.status[`CSB_EV_TEL_WORD])
      else $error("telecom word event lost");

   a_sf0_start_set: assert property ( // RL5
      module_enable && frame_ev.subframe0_start
      |=> st_q.status[`CSB_EV_SF0_START])
      else $error("subframe 0 start event lost");

   a_sf1_start_set: assert property ( // RL6
      module_enable && frame_ev.subframe1_start
      |=> st_q.status[`CSB_EV_SF1_START])
      else $error("subframe 1 start event lost");

   a_pin_rise_delay: assert property ( // RL7
      module_enable && $rose(st_q.pin_sync) && $past(module_enable)
      |=> st_q.status[`CSB_EV_IRQ_RISE])
      else $error("codec pin rise not latched");

   a_pin_fall_set: assert property ( // RL7
      module_enable && $fell(st_q.pin_sync) && $past(module_enable)
      |=> st_q.status[`CSB_EV_IRQ_FALL])
      else $error("codec pin fall not latched");

   a_sound_sel_sf0: assert property ( // RL16
      module_enable && !sound_subframe_select &&
      frame_ev.sound_valid_sf0 |=> st_q.snd_valid)
      else $error("sound flag not taken from subframe 0");

   a_tel_sel_sf1: assert property ( // RL17
      module_enable && telecom_subframe_select &&
      !frame_ev.telecom_valid_sf1 |=> !st_q.tel_valid)
      else $error("telecom flag not taken from subframe 1");

   a_status_sticky: assert property ( // RL1
      module_enable && st_q.status[`CSB_EV_SND_RISE] &&
      !w1c[`CSB_EV_SND_RISE] |=> st_q.status[`CSB_EV_SND_RISE])
      else $error("sticky status bit lost without a clear");

   a_status_w1c: assert property ( // RL5
      module_enable && w1c[`CSB_EV_SF0_START] &&
      !ev[`CSB_EV_SF0_START] |=> !st_q.status[`CSB_EV_SF0_START])
      else $error("status bit not cleared by writing one");

   a_word_irq_out: assert property ( // RL3
      module_enable && frame_ev.sound_word_ready &&
      st_q.mask[`CSB_EV_SND_WORD] && !bus_req.wr |=> irq)
      else $error("unmasked sound word event gave no interrupt");

   a_ctrl_write: assert property ( // RL14
      bus_req.wr && hit(bus_req.addr, `CSB_OFF_CONTROL)
      |=> control_out == $past(bus_req.wdata[30:0]))
      else $error("control write not taken");

   a_sound_size_write: assert property ( // RL8
      bus_req.wr && hit(bus_req.addr, `CSB_OFF_BUF_SIZE)
      |=> st_q.cfg.sound_buffer_size == $past(bus_req.wdata[29:18]))
      else $error("sound size not taken from bits 29 to 18");

   a_tel_size_write: assert property ( // RL10
      bus_req.wr && hit(bus_req.addr, `CSB_OFF_BUF_SIZE)
      |=> st_q.cfg.telecom_buffer_size == $past(bus_req.wdata[13:2]))
      else $error("telecom size not taken from bits 13 to 2");

   a_sound_last_sum: assert property ( // RL9
      ##1 st_q.cfg.sound_rx_last == $past(st_q.cfg.sound_rx_base) +
      {18'h0_0000, $past(st_q.cfg.sound_buffer_size)})
      else $error("sound last entry wrong");

   a_tel_last_sum: assert property ( // RL11
      ##1 st_q.cfg.telecom_tx_last == $past(st_q.cfg.telecom_tx_base) +
      {18'h0_0000, $past(st_q.cfg.telecom_buffer_size)})
      else $error("telecom last entry wrong");

   a_base_separate: assert property ( // RL12
      bus_req.wr && hit(bus_req.addr, `CSB_OFF_SND_RX_BASE)
      |=> $stable(st_q.cfg.sound_tx_base) &&
      st_q.cfg.sound_rx_base == $past(bus_req.wdata[31:2]))
      else $error("sound receive base write disturbed transmit base");

   a_tel_base_write: assert property ( // RL13
      bus_req.wr && hit(bus_req.addr, `CSB_OFF_TEL_TX_BASE)
      |=> $stable(st_q.cfg.telecom_rx_base) &&
      st_q.cfg.telecom_tx_base == $past(bus_req.wdata[31:2]))
      else $error("telecom transmit base write wrong");

   a_ctrl_pin_read: assert property ( // RL14
      bus_req.rd && hit(bus_req.addr, `CSB_OFF_CONTROL)
      |=> rd_data[31] == $past(st_q.pin_sync))
      else $error("control bit 31 does not show codec pin");

   a_disable_clears: assert property ( // RL18
      !module_enable |=> st_q.status == 10'h000 && !irq)
      else $error("disabled module still holds events");

   a_edge_one_cycle: assert property ( // RL19
      ev[`CSB_EV_SND_RISE] |=> !ev[`CSB_EV_SND_RISE])
      else $error("edge event longer than one cycle");

   c_sound_edge: cover property (
      ev[`CSB_EV_SND_RISE] ##[1:200] ev[`CSB_EV_SND_FALL]);
   c_pin_edge: cover property (ev[`CSB_EV_IRQ_RISE]);
   c_irq_clear: cover property (irq ##1 bus_req.wr ##1 !irq);
   c_set_and_clear: cover property (|(ev & w1c));
   c_select_sf1: cover property (
      sound_subframe_select && ev[`CSB_EV_SND_RISE]);

endmodule
`default_nettype wire
